/* verilog/frpc_pkg.sv */
// Purpose: shared constants and types of the flash row program control block
// Assumes: 8-bit register port, 14-bit flash words, 32-word rows
// Notes: register offsets are byte indices on the plain register port
package frpc_pkg;
  localparam int ADDR_W = 15;
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_W = ADDR_W - ADDR_LO_W;
  localparam int DATA_W = 14;
  localparam int DATA_LO_W = 8;
  localparam int DATA_HI_W = DATA_W - DATA_LO_W;
  localparam int IDX_W = 5;
  localparam int ROW_W = ADDR_W - IDX_W;
  localparam int CNT_W = IDX_W + 1;
  localparam int BUS_AW = 4;
  localparam int BUS_DW = 8;
  localparam int PROT_W = 8;
  localparam int IRQ_W = 2;

  // a row holds 32 words, so the stream counter ends at 32
  localparam logic [CNT_W-1:0] CNT_END = 6'h20;
  localparam logic [DATA_W-1:0] ERASED_WORD = 14'h03ff;

  localparam logic [BUS_AW-1:0] REG_ADDR_LO = 4'h0;
  localparam logic [BUS_AW-1:0] REG_ADDR_HI = 4'h1;
  localparam logic [BUS_AW-1:0] REG_DATA_LO = 4'h2;
  localparam logic [BUS_AW-1:0] REG_DATA_HI = 4'h3;
  localparam logic [BUS_AW-1:0] REG_CTRL = 4'h4;
  localparam logic [BUS_AW-1:0] REG_UNLOCK = 4'h5;
  localparam logic [BUS_AW-1:0] REG_IRQ_STAT = 4'h6;
  localparam logic [BUS_AW-1:0] REG_IRQ_MASK = 4'h7;
  localparam logic [BUS_AW-1:0] REG_STATUS = 4'h8;
  localparam logic [BUS_AW-1:0] REG_PROT = 4'h9;

  localparam int CTRL_START = 0;
  localparam int CTRL_WREN = 1;
  localparam int CTRL_ROW_ERASE = 2;
  localparam int CTRL_LATCH_ONLY = 3;
  localparam int CTRL_WERR = 4;

  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;

  localparam int STAT_BUSY = 0;
  localparam int STAT_SWEEP = 1;

  localparam logic [BUS_DW-1:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [BUS_DW-1:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [PROT_W-1:0] PROT_RESET = 8'h00;

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_STREAM, ST_PROG, ST_SWEEP} frpc_state_t;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} frpc_unlock_t;
endpackage

/* verilog/frpc_latch_mem.sv */
// Purpose: the 32 write latches of one flash row
// Assumes: one write port and one read port on the system clock
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module frpc_latch_mem
  import frpc_pkg::*;
(
  input wire logic i_clk_sys,              // system clock
  input wire logic i_we,                   // write enable
  input wire logic [IDX_W-1:0] i_waddr,    // latch written
  input wire logic [DATA_W-1:0] i_wdata,   // word written
  input wire logic [IDX_W-1:0] i_raddr,    // latch read
  output logic [DATA_W-1:0] o_rdata        // registered read word
);
  logic [DATA_W-1:0] mem_q [0:(1<<IDX_W)-1];

  // no reset here: the top sweeps every latch to the erased word after reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule
`default_nettype wire

/* verilog/frpc_unlock.sv */
// Purpose: watches the two-key unlock sequence ahead of a start-write
// Assumes: writes come from the register port on the system clock
// Notes: reads never disturb the sequence
`timescale 1ns/1ps
`default_nettype none
module frpc_unlock
  import frpc_pkg::*;
(
  input wire logic i_clk_sys,              // system clock
  input wire logic i_rst_n,                // synchronised reset, active low
  input wire logic i_wr,                   // register write strobe
  input wire logic [BUS_AW-1:0] i_addr,    // register offset
  input wire logic [BUS_DW-1:0] i_wdata,   // register write data
  output logic o_armed,                    // both keys seen, start may follow
  output logic o_abort                     // sequence broken, one-cycle pulse
);
  frpc_unlock_t st_q;
  logic key_wr;
  logic start_wr;

  assign key_wr = i_wr && (i_addr == REG_UNLOCK);
  assign start_wr = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_START];
  assign o_armed = (st_q == UL_ARMED);
  // any write other than the expected next step breaks the sequence
  assign o_abort = i_wr && (((st_q == UL_KEY1) && !(key_wr && (i_wdata == UNLOCK_KEY2)))
    || ((st_q == UL_ARMED) && !start_wr));

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= UL_IDLE;
    end
    else if (i_wr)
    begin
      case (st_q)
        UL_IDLE: st_q <= (key_wr && (i_wdata == UNLOCK_KEY1)) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: st_q <= (key_wr && (i_wdata == UNLOCK_KEY2)) ? UL_ARMED : UL_IDLE;
        UL_ARMED: st_q <= UL_IDLE;
        default: st_q <= UL_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/frpc_top.sv */
// Purpose: flash row program control: erase a row, load a write latch, program a row
// Assumes: flash array sits on the system clock and answers each request with a done pulse
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// Notes on behaviour
// - start-write at a write-protected address sets the write-error flag.
// - a reset during a flash self-write without power-on reset sets the write-error flag.
// - an interrupted unlock sequence sets the write-error flag.
// - software may set the write-error flag; software or any core reset clears it.
// - row erase select plus start erases the whole 32-word row, data ignored.
// - protected erase or row write: start cleared, error set, flash untouched.
// - latch-only start copies the data pair into the latch picked by low address.
// - latch loads skip write-protection checks; no array access happens.
// - both selects low: start programs the latch contents into the addressed row.
// - after a row write every latch returns to the erased word 3FFh.
`timescale 1ns/1ps
`default_nettype none
module frpc_top
  import frpc_pkg::*;
(
  input wire logic i_clk_sys,                  // system clock, 25 MHz
  input wire logic i_nrst,                     // any reset, active low, async
  input wire logic i_npor,                     // power-on reset, active low, async
  input wire logic [BUS_AW-1:0] i_addr,        // register offset
  input wire logic [BUS_DW-1:0] i_wdata,       // register write data
  input wire logic i_wr,                       // register write strobe
  input wire logic i_rd,                       // register read strobe
  output logic [BUS_DW-1:0] o_rdata,           // register read data, cycle after i_rd
  output logic o_irq,                          // level interrupt
  output logic o_fl_erase,                     // row erase request pulse
  output logic o_fl_prog,                      // row program request pulse
  output logic [ROW_W-1:0] o_fl_row,           // row addressed by the request
  output logic o_fl_lat_we,                    // latch word transfer strobe
  output logic [IDX_W-1:0] o_fl_lat_idx,       // word index in the row
  output logic [DATA_W-1:0] o_fl_lat_data,     // word transferred
  input wire logic i_fl_done                   // array finished erase or program
);
  logic rst_s1_q;
  logic rst_n;
  logic por_s1_q;
  logic por_n;
  frpc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] flash_address_pair_q;
  logic [DATA_W-1:0] flash_data_pair_q;
  logic start_q;
  logic wren_q;
  logic row_erase_q;
  logic latch_only_select_q;
  logic write_error_flag_q;
  logic write_error_flag_d;
  logic [PROT_W-1:0] prot_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_event;
  logic rst_mark_q;
  logic armed;
  logic abort;
  logic wr_ctrl;
  logic start_req;
  logic sel_erase;
  logic sel_latch;
  logic prot_hit;
  logic op_done;
  logic in_self_write;
  logic mem_we;
  logic [IDX_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [BUS_DW-1:0] rd_mux;

  // protected region: rows below the boundary held in the protect register
  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [PROT_W-1:0] lim);
    is_protected = (a[ADDR_W-1 -: PROT_W] < lim);
  endfunction

  // reset releases pass two flops
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_npor)
  begin
    if (!i_npor)
    begin
      por_s1_q <= 1'b0;
      por_n <= 1'b0;
    end
    else
    begin
      por_s1_q <= 1'b1;
      por_n <= por_s1_q;
    end
  end

  frpc_unlock u_unlock (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_armed(armed),
    .o_abort(abort)
  );

  assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
  // start needs the unlock keys, the enable bit and an idle sequencer
  assign start_req = wr_ctrl && i_wdata[CTRL_START] && i_wdata[CTRL_WREN] && armed && (state_q == ST_IDLE);
  assign sel_erase = i_wdata[CTRL_ROW_ERASE];
  assign sel_latch = !i_wdata[CTRL_ROW_ERASE] && i_wdata[CTRL_LATCH_ONLY];
  // latch loads never touch the array, so protection is not looked at
  assign prot_hit = start_req && !sel_latch && is_protected(flash_address_pair_q, prot_q);
  assign in_self_write = (state_q == ST_ERASE) || (state_q == ST_STREAM) || (state_q == ST_PROG);

  // last sequencer activity, frozen while the core reset is low; only power-on clears it
  always_ff @(posedge i_clk_sys or negedge por_n)
  begin
    if (!por_n)
      rst_mark_q <= 1'b0;
    else if (rst_n)
      rst_mark_q <= in_self_write;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_SWEEP;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          cnt_q <= '0;
          if (start_req && !prot_hit && !sel_latch)
            state_q <= sel_erase ? ST_ERASE : ST_STREAM;
        end
        ST_ERASE:
        begin
          if (i_fl_done)
            state_q <= ST_IDLE;
        end
        ST_STREAM:
        begin
          if (cnt_q == CNT_END)
          begin
            state_q <= ST_PROG;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_PROG:
        begin
          if (i_fl_done)
            state_q <= ST_SWEEP;
        end
        ST_SWEEP:
        begin
          if (cnt_q == CNT_END - 1'b1)
          begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        default:
        begin
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // one write port shared by latch loads and the erase sweep
  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = flash_address_pair_q[IDX_W-1:0];
    mem_wdata = flash_data_pair_q;
    if (state_q == ST_SWEEP)
    begin
      mem_we = 1'b1;
      mem_waddr = cnt_q[IDX_W-1:0];
      mem_wdata = ERASED_WORD;
    end
    else if (start_req && sel_latch)
      mem_we = 1'b1;
  end

  frpc_latch_mem u_latch (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(cnt_q[IDX_W-1:0]),
    .o_rdata(o_fl_lat_data)
  );

  // array side: read data lag the index by one cycle, so strobe and index follow suit
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_fl_lat_we <= 1'b0;
      o_fl_lat_idx <= '0;
      o_fl_erase <= 1'b0;
      o_fl_prog <= 1'b0;
      o_fl_row <= '0;
    end
    else
    begin
      o_fl_lat_we <= (state_q == ST_STREAM) && (cnt_q != CNT_END);
      o_fl_lat_idx <= cnt_q[IDX_W-1:0];
      o_fl_erase <= start_req && !prot_hit && sel_erase;
      o_fl_prog <= (state_q == ST_STREAM) && (cnt_q == CNT_END);
      if (start_req)
        o_fl_row <= flash_address_pair_q[ADDR_W-1:IDX_W];
    end
  end

  assign op_done = ((state_q == ST_ERASE) && i_fl_done) || ((state_q == ST_SWEEP) && start_q
    && (cnt_q == CNT_END - 1'b1)) || (start_req && sel_latch);

  // start-write: set only through a good start, cleared by hardware on completion
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      start_q <= 1'b0;
    else if (start_req && !prot_hit && !sel_latch)
      start_q <= 1'b1;
    else if (op_done)
      start_q <= 1'b0;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wren_q <= 1'b0;
      row_erase_q <= 1'b0;
      latch_only_select_q <= 1'b0;
    end
    else if (wr_ctrl && (state_q == ST_IDLE))
    begin
      wren_q <= i_wdata[CTRL_WREN];
      row_erase_q <= i_wdata[CTRL_ROW_ERASE];
      latch_only_select_q <= i_wdata[CTRL_LATCH_ONLY];
    end
  end

  // hardware set wins over a software clear in the same cycle;
  // a sweep entered with start low only ever follows a core reset
  always_comb
  begin
    write_error_flag_d = wr_ctrl ? i_wdata[CTRL_WERR] : write_error_flag_q;
    if (prot_hit || abort || (rst_mark_q && !start_q && (state_q == ST_SWEEP) && (cnt_q == '0)))
      write_error_flag_d = 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      write_error_flag_q <= 1'b0;
    else
      write_error_flag_q <= write_error_flag_d;
  end

  // address and data pair are frozen while the sequencer works
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_address_pair_q <= '0;
      flash_data_pair_q <= '0;
      prot_q <= PROT_RESET;
    end
    else if (i_wr && (state_q == ST_IDLE))
    begin
      case (i_addr)
        REG_ADDR_LO: flash_address_pair_q[ADDR_LO_W-1:0] <= i_wdata;
        REG_ADDR_HI: flash_address_pair_q[ADDR_W-1:ADDR_LO_W] <= i_wdata[ADDR_HI_W-1:0];
        REG_DATA_LO: flash_data_pair_q[DATA_LO_W-1:0] <= i_wdata;
        REG_DATA_HI: flash_data_pair_q[DATA_W-1:DATA_LO_W] <= i_wdata[DATA_HI_W-1:0];
        REG_PROT: prot_q <= i_wdata;
        default: prot_q <= prot_q;
      endcase
    end
  end

  assign irq_event[IRQ_DONE] = op_done;
  assign irq_event[IRQ_ERR] = write_error_flag_d && !write_error_flag_q;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end
    else
    begin
      if (i_wr && (i_addr == REG_IRQ_STAT))
        irq_stat_q <= (irq_stat_q & ~i_wdata[IRQ_W-1:0]) | irq_event;
      else
        irq_stat_q <= irq_stat_q | irq_event;
      if (i_wr && (i_addr == REG_IRQ_MASK))
        irq_mask_q <= i_wdata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  always_comb
  begin
    rd_mux = '0;
    case (i_addr)
      REG_ADDR_LO: rd_mux = flash_address_pair_q[ADDR_LO_W-1:0];
      REG_ADDR_HI: rd_mux[ADDR_HI_W-1:0] = flash_address_pair_q[ADDR_W-1:ADDR_LO_W];
      REG_DATA_LO: rd_mux = flash_data_pair_q[DATA_LO_W-1:0];
      REG_DATA_HI: rd_mux[DATA_HI_W-1:0] = flash_data_pair_q[DATA_W-1:DATA_LO_W];
      REG_CTRL:
      begin
        rd_mux[CTRL_START] = start_q;
        rd_mux[CTRL_WREN] = wren_q;
        rd_mux[CTRL_ROW_ERASE] = row_erase_q;
        rd_mux[CTRL_LATCH_ONLY] = latch_only_select_q;
        rd_mux[CTRL_WERR] = write_error_flag_q;
      end
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      REG_STATUS:
      begin
        rd_mux[STAT_BUSY] = (state_q != ST_IDLE);
        rd_mux[STAT_SWEEP] = (state_q == ST_SWEEP);
      end
      REG_PROT: rd_mux = prot_q;
      default: rd_mux = '0;
    endcase
  end

  // unread cycles drive zero so the data only stand in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= '0;
    else
      o_rdata <= i_rd ? rd_mux : '0;
  end
endmodule
`default_nettype wire

/* verification/frpc_monitor.sv */
// Purpose: port-level checks of frpc_top
// Assumes: sees only the top module's ports
// Notes: bound to every frpc_top at the file foot
`timescale 1ns/1ps
`default_nettype none
module frpc_monitor
  import frpc_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_nrst, // reset, active low
  input wire logic [BUS_AW-1:0] i_addr, // offset
  input wire logic [BUS_DW-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [BUS_DW-1:0] o_rdata, // read data
  input wire logic o_irq, // interrupt
  input wire logic o_fl_erase, // erase request
  input wire logic o_fl_prog, // program request
  input wire logic o_fl_lat_we, // word strobe
  input wire logic [IDX_W-1:0] o_fl_lat_idx // word index
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  a_erase_after_start: assert property (o_fl_erase |->
    $past(i_wr && i_addr == REG_CTRL && i_wdata[CTRL_START]))
    else $error("erase request without a start write");
  a_erase_alone: assert property (o_fl_erase |-> !o_fl_prog && !o_fl_lat_we ##1 !o_fl_erase)
    else $error("erase request overlaps other traffic");
  a_burst_from_zero: assert property ($rose(o_fl_lat_we) |-> o_fl_lat_idx == 5'h00)
    else $error("latch burst does not start at word 0");
  a_burst_steps: assert property (o_fl_lat_we && o_fl_lat_idx != 5'h1f |=>
    o_fl_lat_we && o_fl_lat_idx == $past(o_fl_lat_idx) + 5'h01)
    else $error("latch burst skipped or stopped");
  a_prog_after_burst: assert property (o_fl_prog |->
    $past(o_fl_lat_we) && $past(o_fl_lat_idx) == 5'h1f && !o_fl_lat_we)
    else $error("program request before a full burst");
  a_unlock_broken: assert property ((i_wr && i_addr == REG_UNLOCK && i_wdata == UNLOCK_KEY1) ##1
    (i_wr && i_addr != REG_UNLOCK) ##1 (i_rd && i_addr == REG_CTRL) |=> o_rdata[CTRL_WERR])
    else $error("broken unlock left error flag clear");
  a_werr_sticky: assert property ((i_wr && i_addr == REG_CTRL && i_wdata[CTRL_WERR]) ##1
    (i_rd && i_addr == REG_CTRL) |=> o_rdata[CTRL_WERR])
    else $error("software set of error flag lost");
  a_mask_off: assert property (i_wr && i_addr == REG_IRQ_MASK && i_wdata[1:0] == 2'b00 |=> !o_irq)
    else $error("interrupt high with all sources masked");
  a_rdata_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside a read answer");
endmodule
bind frpc_top frpc_monitor mon (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog),
  .o_fl_lat_we(o_fl_lat_we), .o_fl_lat_idx(o_fl_lat_idx));
`default_nettype wire

/* verification/frpc_flash_model.sv */
// Purpose: behavioural program flash array behind frpc_top
// Assumes: requests and done pulse on the system clock
// Notes: done latency set by i_dly, so slow and prompt answers are both possible
`timescale 1ns/1ps
`default_nettype none
module frpc_flash_model
  import frpc_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_nrst, // reset, active low
  input wire logic i_erase, // erase request
  input wire logic i_prog, // program request
  input wire logic [ROW_W-1:0] i_row, // row addressed
  input wire logic i_we, // word strobe
  input wire logic [IDX_W-1:0] i_idx, // word index
  input wire logic [DATA_W-1:0] i_data, // word
  input wire logic [7:0] i_dly, // cycles to done, at least 1
  output logic o_done // done pulse
);
  logic [DATA_W-1:0] words_q [32];
  logic [ROW_W-1:0] row_q;
  logic [7:0] wait_q;
  int erase_cnt = 0;
  int prog_cnt = 0;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_q <= 8'h00;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= (wait_q == 8'h01);
      // a request restarts the wait, done never comes unasked
      if (i_erase || i_prog)
        wait_q <= i_dly;
      else if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
    end
  end
  always @(posedge i_clk_sys)
  begin
    if (i_we)
      words_q[i_idx] <= i_data;
    if (i_erase || i_prog)
      row_q <= i_row;
    if (i_erase)
      erase_cnt++;
    if (i_prog)
      prog_cnt++;
  end
endmodule
`default_nettype wire

/* verification/test_flash_row_program_control.sv */
// Purpose: self-checking bench of frpc_top with a flash array model
// Assumes: 25 MHz clock, register port driven after rising edges
// Notes: register table rows first, then sequencing and error cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module test_flash_row_program_control;
  import frpc_pkg::*;
  typedef struct {logic [BUS_AW-1:0] a; logic [BUS_DW-1:0] wd;
    logic [BUS_DW-1:0] rst; logic [BUS_DW-1:0] exp;} frpc_case_t;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_npor = 1'b0;
  logic [BUS_AW-1:0] i_addr = '0;
  logic [BUS_DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [BUS_DW-1:0] o_rdata;
  logic o_irq, o_fl_erase, o_fl_prog, o_fl_lat_we, i_fl_done;
  logic [ROW_W-1:0] o_fl_row;
  logic [IDX_W-1:0] o_fl_lat_idx;
  logic [DATA_W-1:0] o_fl_lat_data;
  logic [7:0] dly = 8'h04;
  logic [BUS_DW-1:0] v;
  int err_total = 0;
  int checks = 0;
  frpc_case_t tbl [7] = '{'{REG_ADDR_LO, 8'h5a, 8'h00, 8'h5a}, '{REG_ADDR_HI, 8'hff, 8'h00, 8'h7f},
    '{REG_DATA_LO, 8'ha5, 8'h00, 8'ha5}, '{REG_DATA_HI, 8'hff, 8'h00, 8'h3f}, '{REG_PROT, 8'h3c, PROT_RESET, 8'h3c},
    '{REG_IRQ_MASK, 8'hff, 8'h00, 8'h03}, '{4'hc, 8'hff, 8'h00, 8'h00}};
  frpc_top dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_npor(i_npor), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog),
    .o_fl_row(o_fl_row), .o_fl_lat_we(o_fl_lat_we), .o_fl_lat_idx(o_fl_lat_idx), .o_fl_lat_data(o_fl_lat_data),
    .i_fl_done(i_fl_done));
  frpc_flash_model mdl (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_erase(o_fl_erase), .i_prog(o_fl_prog),
    .i_row(o_fl_row), .i_we(o_fl_lat_we), .i_idx(o_fl_lat_idx), .i_data(o_fl_lat_data), .i_dly(dly),
    .o_done(i_fl_done));
  initial
  begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  task automatic cyc(input logic w, input logic r, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask
  // answer stands one cycle only, so take it just after the edge
  task automatic rd(input logic [BUS_AW-1:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
    #1 v = o_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rd(REG_STATUS);
    while (v[STAT_BUSY] !== 1'b0 && n < 300)
    begin
      rd(REG_STATUS);
      n++;
    end
    `CHK(v[STAT_BUSY], 1'b0)
  endtask
  task automatic do_rst(input logic por);
    i_nrst <= 1'b0;
    i_npor <= !por;
    idle(8);
    i_nrst <= 1'b1;
    i_npor <= 1'b1;
    idle(3);
    wait_idle();
  endtask
  task automatic start(input logic [BUS_DW-1:0] sel);
    wr(REG_UNLOCK, UNLOCK_KEY1);
    wr(REG_UNLOCK, UNLOCK_KEY2);
    wr(REG_CTRL, sel | 8'h03);
  endtask
  task automatic set_addr(input logic [ADDR_W-1:0] a);
    wr(REG_ADDR_LO, a[7:0]);
    wr(REG_ADDR_HI, {1'b0, a[14:8]});
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 30000);
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    do_rst(1'b1);
    foreach (tbl[k])
    begin
      rd(tbl[k].a);
      `CHK(v, tbl[k].rst)
      wr(tbl[k].a, tbl[k].wd);
      rd(tbl[k].a);
      `CHK(v, tbl[k].exp)
    end
    $display("register table done");
    // latch load into a protected row must still work
    wr(REG_PROT, 8'h01);
    set_addr(15'h0043);
    wr(REG_DATA_LO, 8'h5c);
    wr(REG_DATA_HI, 8'h1a);
    wr(REG_IRQ_STAT, 8'h03);
    start(8'h08);
    rd(REG_CTRL);
    `CHK(v[CTRL_WERR], 1'b0)
    `CHK(v[CTRL_START], 1'b0)
    rd(REG_IRQ_STAT);
    `CHK(v[IRQ_DONE], 1'b1)
    $display("latch load done");
    for (int k = 0; k < 2; k++)
    begin
      // clear the latch-load done bit so the irq check sees the error alone
      wr(REG_IRQ_STAT, 8'h03);
      start(k == 0 ? 8'h00 : 8'h04);
      rd(REG_CTRL);
      `CHK(v[CTRL_WERR], 1'b1)
      `CHK(v[CTRL_START], 1'b0)
      idle(40);
      `CHK(mdl.prog_cnt + mdl.erase_cnt, 0)
      `CHK(o_irq, 1'b1)
      wr(REG_CTRL, 8'h00);
      rd(REG_CTRL);
      `CHK(v[CTRL_WERR], 1'b0)
    end
    $display("protected start done");
    wr(REG_PROT, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      start(8'h00);
      rd(REG_CTRL);
      `CHK(v[CTRL_START], 1'b1)
      wait_idle();
      for (int i = 0; i < 32; i++)
        `CHK(mdl.words_q[i], (i == 3 && p == 0) ? 14'h1a5c : ERASED_WORD)
      `CHK(mdl.row_q, 10'h002)
      `CHK(mdl.prog_cnt, p + 1)
      rd(REG_CTRL);
      `CHK(v[CTRL_START], 1'b0)
      `CHK(v[CTRL_WERR], 1'b0)
    end
    // second pass saw only erased words, so the latches were reset
    $display("row write done");
    dly <= 8'd30;
    set_addr(15'h00a0);
    start(8'h04);
    idle(5);
    rd(REG_CTRL);
    `CHK(v[CTRL_START], 1'b1)
    `CHK(mdl.erase_cnt, 1)
    `CHK(mdl.row_q, 10'h005)
    wait_idle();
    rd(REG_CTRL);
    `CHK(v[CTRL_START], 1'b0)
    `CHK(mdl.prog_cnt, 2)
    `CHK(v[CTRL_WERR], 1'b0)
    $display("row erase done");
    wr(REG_IRQ_STAT, 8'h03);
    wr(REG_UNLOCK, UNLOCK_KEY1);
    wr(REG_IRQ_MASK, 8'h02);
    rd(REG_CTRL);
    `CHK(v[CTRL_WERR], 1'b1)
    rd(REG_IRQ_STAT);
    `CHK(o_irq, 1'b1)
    wr(REG_IRQ_STAT, 8'h02);
    rd(REG_CTRL);
    `CHK(o_irq, 1'b0)
    `CHK(v[CTRL_WERR], 1'b1)
    wr(REG_CTRL, 8'h00);
    wr(REG_CTRL, 8'h10);
    rd(REG_CTRL);
    idle(20);
    `CHK(v[CTRL_WERR], 1'b1)
    wr(REG_IRQ_MASK, 8'h00);
    idle(1);
    `CHK(o_irq, 1'b0)
    $display("error flag done");
    wr(REG_CTRL, 8'h00);
    dly <= 8'd200;
    start(8'h00);
    idle(40);
    do_rst(1'b0);
    rd(REG_CTRL);
    `CHK(v[CTRL_WERR], 1'b1)
    $display("reset during write done");
    finish_test();
  end
endmodule
`default_nettype wire
